// ===== common/pvrb_pkg.sv
// Constants, field layout and helpers for the transceiver vendor register bank.
// Assumes one 125 MHz core clock shared by the link end and the transceiver end.
package pvrb_pkg;

	// Vendor register addresses (immediate 6-bit address space)
	localparam logic [5:0] VND_LOW_ADDR      = 6'h30;
	localparam logic [5:0] VND_HIGH_ADDR     = 6'h3f;
	localparam logic [5:0] TX_BOOST_ADDR     = 6'h31;
	localparam logic [5:0] AUDIO_KEY_ADDR    = 6'h33;
	localparam logic [5:0] ID_MEAS_ADDR      = 6'h36;
	localparam logic [5:0] ID_MEAS_SET_ADDR  = 6'h37;
	localparam logic [5:0] ID_MEAS_CLR_ADDR  = 6'h38;
	localparam logic [5:0] LINE_IO_ADDR      = 6'h39;
	localparam logic [5:0] GROUP_SET_STEP    = 6'h01;
	localparam logic [5:0] GROUP_CLR_STEP    = 6'h02;

	// Field positions
	localparam int BOOST_LSB       = 5;
	localparam int AUDIO_KEY_LSB   = 0;
	localparam int ID_CODE_LSB     = 0;
	localparam int ID_DONE_BIT     = 3;
	localparam int ID_GO_BIT       = 4;
	localparam int ID_KEEP0_BIT    = 5;
	localparam int ID_IRQ_EN_BIT   = 6;
	localparam int SWAP_BIT        = 1;
	localparam int SER_LDO_LSB     = 2;
	localparam int PULL_PLUS_BIT   = 4;
	localparam int PULL_MINUS_BIT  = 5;
	localparam int USB_LDO_LSB     = 6;
	localparam int RXCMD_ALT_BIT   = 7;

	// Codes and values after reset
	localparam logic [3:0] AUDIO_KEY_CODE  = 4'ha;
	localparam logic [1:0] BOOST_RESERVED  = 2'h1;
	localparam logic [1:0] BOOST_NOMINAL   = 2'h0;
	localparam logic [1:0] BOOST_RST       = 2'h0;
	localparam logic [3:0] AUDIO_KEY_RST   = 4'h0;
	localparam logic [7:0] ID_MEAS_RST     = 8'h00;
	localparam logic [1:0] SER_LDO_RST     = 2'h1;
	localparam logic [1:0] USB_LDO_RST     = 2'h0;
	localparam logic [7:0] LINE_IO_RST     = 8'h04;
	localparam logic [7:0] RXCMD_ALT_BYTE  = 8'h80;

	// Conversion time: least time, rounded up to whole cycles
	localparam int CLK_PERIOD_PS    = 8000;
	localparam int ID_CONV_TIME_US  = 282;
	localparam int ID_CONV_CYCLES   = (ID_CONV_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;

	// Controller software register offsets and bits
	localparam logic [3:0] SW_PHY_ADDR_OFS = 4'h0;
	localparam logic [3:0] SW_PHY_DATA_OFS = 4'h1;
	localparam logic [3:0] SW_CTRL_OFS     = 4'h2;
	localparam logic [3:0] SW_RDATA_OFS    = 4'h3;
	localparam logic [3:0] SW_IRQ_STAT_OFS = 4'h4;
	localparam logic [3:0] SW_IRQ_MASK_OFS = 4'h5;
	localparam int CTRL_WRITE_BIT   = 0;
	localparam int CTRL_READ_BIT    = 1;
	localparam int IRQ_RDONE_BIT    = 0;
	localparam int IRQ_ALT_BIT      = 1;

	// New register value after a direct, set or clear access to a three-address group
	function automatic logic [7:0] pvrb_apply(input logic [7:0] old, input logic [7:0] data,
		input logic [5:0] addr, input logic [5:0] base);
		if (addr == base)
			return data;
		else if (addr == base + GROUP_SET_STEP)
			return old | data;
		else if (addr == base + GROUP_CLR_STEP)
			return old & ~data;
		else
			return old;
	endfunction

	// Address falls in a three-address group
	function automatic logic pvrb_in_group(input logic [5:0] addr, input logic [5:0] base);
		return (addr >= base) && (addr <= base + GROUP_CLR_STEP);
	endfunction

endpackage

// ===== common/pvrb_link_if.sv
// Register command channel between link controller and transceiver.
// Assumes both ends are clocked by the same core clock.
`timescale 1ns/1ps
interface pvrb_link_if;
	logic       cmd_wr;      // One-cycle register write
	logic       cmd_rd;      // One-cycle register read
	logic [5:0] cmd_addr;
	logic [7:0] cmd_data;
	logic       rd_valid;    // Read answer, cycle after cmd_rd
	logic [7:0] rd_data;
	logic       rxcmd_valid; // One-cycle status byte
	logic [7:0] rxcmd_data;

	modport phy  (input cmd_wr, cmd_rd, cmd_addr, cmd_data,
		output rd_valid, rd_data, rxcmd_valid, rxcmd_data);
	modport link (output cmd_wr, cmd_rd, cmd_addr, cmd_data,
		input rd_valid, rd_data, rxcmd_valid, rxcmd_data);
endinterface

// ===== logic/pvrb_phy_end.sv
// Transceiver end: vendor register bank, ID-resistor conversion timing, pin controls.
// Assumes the link keeps the keep-zero bit clear and issues one strobe per cycle.
`timescale 1ns/1ps
module pvrb_phy_end
	import pvrb_pkg::*;
#(
	parameter int CONV_CYCLES = ID_CONV_CYCLES
)
(
	// Clock and reset
	input  wire logic       CORE_CLK,
	input  wire logic       NRST,
	// Link side
	pvrb_link_if.phy        LINK,
	// Converter and mode inputs
	input  wire logic [2:0] ID_RES_CODE_IN,
	input  wire logic       CARKIT_IRQ_EN,
	input  wire logic       UART_MODE,
	input  wire logic       SERIAL_TRANSMIT_DRIVE_ENABLE,
	// Analog and pin controls
	output logic      [1:0] TX_AMPLITUDE_BOOST,
	output logic            AUDIO_MODE_ENABLE,
	output logic            ID_MEASURE_ACTIVE,
	output logic            ID_MEASURE_DONE,
	output logic      [2:0] ID_RESISTANCE_CODE,
	output logic            LINE_POLARITY_SWAP,
	output logic      [1:0] LDO_LEVEL,
	output logic            CHARGER_PULLUP_PLUS,
	output logic            CHARGER_PULLUP_MINUS
);

	// Register state
	logic [1:0]  boost_q;
	logic [3:0]  audio_mode_key_q;
	logic [2:0]  id_resistance_code_q;
	logic        id_measure_done_q;
	logic        id_measure_go_q;
	logic        id_keep0_q;
	logic        id_measure_irq_enable_q;
	logic [7:1]  line_io_q;
	logic [15:0] conv_cnt_q;
	logic [2:0]  code_s1_q;
	logic [2:0]  code_s2_q;
	logic        alt_pend_q;
	logic        rd_valid_q;
	logic [7:0]  rd_data_q;
	logic        rxcmd_valid_q;
	logic [7:0]  rxcmd_data_q;

	// Combinational views
	logic [7:0]  id_view;
	logic [7:0]  io_view;
	logic [7:0]  id_new;
	logic [7:0]  io_new;
	logic        id_hit_wr;
	logic        io_hit_wr;
	logic        id_measure_go_d;
	logic        conv_start;
	logic        conv_end;
	logic        done_rd_clear;
	logic        alt_event;
	logic        alt_send;
	logic [7:0]  rd_mux;

	// Readable images; unused bits read zero
	always_comb
	begin
		id_view = 8'h00;
		id_view[ID_CODE_LSB +: 3]  = id_resistance_code_q;
		id_view[ID_DONE_BIT]       = id_measure_done_q;
		id_view[ID_GO_BIT]         = id_measure_go_q;
		id_view[ID_KEEP0_BIT]      = id_keep0_q;
		id_view[ID_IRQ_EN_BIT]     = id_measure_irq_enable_q;
		io_view = {line_io_q, 1'b0};
	end

	// Write decode for the two grouped registers
	always_comb
	begin
		id_hit_wr = LINK.cmd_wr && pvrb_in_group(LINK.cmd_addr, ID_MEAS_ADDR);
		io_hit_wr = LINK.cmd_wr && pvrb_in_group(LINK.cmd_addr, LINE_IO_ADDR);
		id_new = pvrb_apply(id_view, LINK.cmd_data, LINK.cmd_addr, ID_MEAS_ADDR);
		io_new = pvrb_apply(io_view, LINK.cmd_data, LINK.cmd_addr, LINE_IO_ADDR);
	end

	// Conversion control: start on rising go, completion clears go
	always_comb
	begin
		conv_end = id_measure_go_q && (conv_cnt_q == 16'h0000);
		if (conv_end)
			id_measure_go_d = 1'b0;
		else if (id_hit_wr)
			id_measure_go_d = id_new[ID_GO_BIT];
		else
			id_measure_go_d = id_measure_go_q;
		conv_start = id_measure_go_d && !id_measure_go_q;
		done_rd_clear = LINK.cmd_rd && pvrb_in_group(LINK.cmd_addr, ID_MEAS_ADDR);
		alt_event = conv_end && (id_measure_irq_enable_q || CARKIT_IRQ_EN);
		alt_send = alt_pend_q && !LINK.cmd_rd;
	end

	// Simple read/write registers
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			boost_q          <= BOOST_RST;
			audio_mode_key_q <= AUDIO_KEY_RST;
		end
		else if (LINK.cmd_wr)
		begin
			if (LINK.cmd_addr == TX_BOOST_ADDR)
				boost_q <= LINK.cmd_data[BOOST_LSB +: 2];
			if (LINK.cmd_addr == AUDIO_KEY_ADDR)
				audio_mode_key_q <= LINK.cmd_data[AUDIO_KEY_LSB +: 4];
		end
	end

	// ID measurement writable bits
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			id_measure_go_q         <= ID_MEAS_RST[ID_GO_BIT];
			id_keep0_q              <= ID_MEAS_RST[ID_KEEP0_BIT];
			id_measure_irq_enable_q <= ID_MEAS_RST[ID_IRQ_EN_BIT];
		end
		else
		begin
			id_measure_go_q <= id_measure_go_d;
			if (id_hit_wr)
			begin
				id_keep0_q              <= id_new[ID_KEEP0_BIT];
				id_measure_irq_enable_q <= id_new[ID_IRQ_EN_BIT];
			end
		end
	end

	// Conversion timer
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			conv_cnt_q <= 16'h0000;
		else if (conv_start)
			conv_cnt_q <= 16'(CONV_CYCLES - 1);
		else if (id_measure_go_q && conv_cnt_q != 16'h0000)
			conv_cnt_q <= conv_cnt_q - 16'h0001;
	end

	// Converter result synchroniser
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			code_s1_q <= 3'h0;
			code_s2_q <= 3'h0;
		end
		else
		begin
			code_s1_q <= ID_RES_CODE_IN;
			code_s2_q <= code_s1_q;
		end
	end

	// Result capture and done flag; completion wins over a read clear
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			id_resistance_code_q <= ID_MEAS_RST[ID_CODE_LSB +: 3];
			id_measure_done_q    <= ID_MEAS_RST[ID_DONE_BIT];
		end
		else if (conv_end)
		begin
			id_resistance_code_q <= code_s2_q;
			id_measure_done_q    <= 1'b1;
		end
		else if (done_rd_clear)
			id_measure_done_q <= 1'b0;
	end

	// Line I/O and power register, bit 0 never stored
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			line_io_q <= LINE_IO_RST[7:1];
		else if (io_hit_wr)
			line_io_q <= io_new[7:1];
	end

	// Pending alt_int; a new event wins over the send
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			alt_pend_q <= 1'b0;
		else
			alt_pend_q <= alt_event || (alt_pend_q && !alt_send);
	end

	// Status byte, held off while a read answer owns the next cycle
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			rxcmd_valid_q <= 1'b0;
			rxcmd_data_q  <= 8'h00;
		end
		else
		begin
			rxcmd_valid_q <= alt_send;
			rxcmd_data_q  <= alt_send ? RXCMD_ALT_BYTE : 8'h00;
		end
	end

	// Read multiplexer; unmapped addresses answer zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (LINK.cmd_addr == TX_BOOST_ADDR)
			rd_mux[BOOST_LSB +: 2] = boost_q;
		else if (LINK.cmd_addr == AUDIO_KEY_ADDR)
			rd_mux[AUDIO_KEY_LSB +: 4] = audio_mode_key_q;
		else if (pvrb_in_group(LINK.cmd_addr, ID_MEAS_ADDR))
			rd_mux = id_view;
		else if (pvrb_in_group(LINK.cmd_addr, LINE_IO_ADDR))
			rd_mux = io_view;
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= 8'h00;
		end
		else
		begin
			rd_valid_q <= LINK.cmd_rd;
			rd_data_q  <= LINK.cmd_rd ? rd_mux : 8'h00;
		end
	end

	assign LINK.rd_valid    = rd_valid_q;
	assign LINK.rd_data     = rd_data_q;
	assign LINK.rxcmd_valid = rxcmd_valid_q;
	assign LINK.rxcmd_data  = rxcmd_data_q;

	// Registered analog and pin controls
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			TX_AMPLITUDE_BOOST          <= BOOST_NOMINAL;
			AUDIO_MODE_ENABLE    <= 1'b0;
			LINE_POLARITY_SWAP   <= 1'b0;
			LDO_LEVEL            <= USB_LDO_RST;
			CHARGER_PULLUP_PLUS  <= 1'b0;
			CHARGER_PULLUP_MINUS <= 1'b0;
		end
		else
		begin
			TX_AMPLITUDE_BOOST <= (boost_q == BOOST_RESERVED) ? BOOST_NOMINAL : boost_q;
			AUDIO_MODE_ENABLE  <= (audio_mode_key_q == AUDIO_KEY_CODE);
			LINE_POLARITY_SWAP <= line_io_q[SWAP_BIT];
			if (UART_MODE && SERIAL_TRANSMIT_DRIVE_ENABLE)
				LDO_LEVEL <= line_io_q[SER_LDO_LSB +: 2];
			else
				LDO_LEVEL <= line_io_q[USB_LDO_LSB +: 2];
			CHARGER_PULLUP_PLUS  <= line_io_q[PULL_PLUS_BIT] || UART_MODE;
			CHARGER_PULLUP_MINUS <= line_io_q[PULL_MINUS_BIT] || UART_MODE;
		end
	end

	// Measurement state for the carkit status mirror
	assign ID_MEASURE_ACTIVE  = id_measure_go_q;
	assign ID_MEASURE_DONE    = id_measure_done_q;
	assign ID_RESISTANCE_CODE = id_resistance_code_q;

endmodule

// ===== logic/pvrb_link_end.sv
// Link controller end: issues vendor register reads and writes for software.
// Assumes the transceiver answers every read exactly one cycle after the strobe.
`timescale 1ns/1ps
module pvrb_link_end
	import pvrb_pkg::*;
(
	// Clock and reset
	input  wire logic       CORE_CLK,
	input  wire logic       NRST,
	// Software register port
	input  wire logic [3:0] SW_ADDR,
	input  wire logic [7:0] SW_WDATA,
	input  wire logic       SW_WR,
	input  wire logic       SW_RD,
	output logic      [7:0] SW_RDATA,
	output logic            IRQ,
	// Transceiver side
	pvrb_link_if.link       LINK
);

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT  = 3'b100
	} pvrb_state_type;

	pvrb_state_type state_q;
	logic [5:0] phy_addr_q;
	logic [7:0] phy_data_q;
	logic [7:0] rdata_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic       is_read_q;
	logic       cmd_wr_q;
	logic       cmd_rd_q;
	logic [5:0] cmd_addr_q;
	logic [7:0] cmd_data_q;
	logic [7:0] sw_rdata_q;
	logic       ctrl_wr;
	logic       go_write;
	logic       go_read;
	logic       rdone_set;
	logic       alt_set;

	// Command decode; requests while busy are dropped
	assign ctrl_wr   = SW_WR && (SW_ADDR == SW_CTRL_OFS);
	assign go_write  = ctrl_wr && (state_q == ST_IDLE) && SW_WDATA[CTRL_WRITE_BIT];
	assign go_read   = ctrl_wr && (state_q == ST_IDLE) && !SW_WDATA[CTRL_WRITE_BIT]
		&& SW_WDATA[CTRL_READ_BIT];
	assign rdone_set = (state_q == ST_WAIT) && LINK.rd_valid;
	assign alt_set   = LINK.rxcmd_valid && LINK.rxcmd_data[RXCMD_ALT_BIT];

	// Software setup registers
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			phy_addr_q <= 6'h00;
			phy_data_q <= 8'h00;
			irq_mask_q <= 2'h0;
		end
		else if (SW_WR)
		begin
			if (SW_ADDR == SW_PHY_ADDR_OFS)
				phy_addr_q <= SW_WDATA[5:0];
			if (SW_ADDR == SW_PHY_DATA_OFS)
				phy_data_q <= SW_WDATA;
			if (SW_ADDR == SW_IRQ_MASK_OFS)
				irq_mask_q <= SW_WDATA[1:0];
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			irq_stat_q <= 2'h0;
		else
		begin
			if (rdone_set)
				irq_stat_q[IRQ_RDONE_BIT] <= 1'b1;
			else if (SW_WR && SW_ADDR == SW_IRQ_STAT_OFS && SW_WDATA[IRQ_RDONE_BIT])
				irq_stat_q[IRQ_RDONE_BIT] <= 1'b0;
			if (alt_set)
				irq_stat_q[IRQ_ALT_BIT] <= 1'b1;
			else if (SW_WR && SW_ADDR == SW_IRQ_STAT_OFS && SW_WDATA[IRQ_ALT_BIT])
				irq_stat_q[IRQ_ALT_BIT] <= 1'b0;
		end
	end

	// Transfer sequencer and link strobes
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			state_q    <= ST_IDLE;
			is_read_q  <= 1'b0;
			cmd_wr_q   <= 1'b0;
			cmd_rd_q   <= 1'b0;
			cmd_addr_q <= 6'h00;
			cmd_data_q <= 8'h00;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (go_write || go_read)
					begin
						state_q    <= ST_ISSUE;
						is_read_q  <= go_read;
						cmd_wr_q   <= go_write;
						cmd_rd_q   <= go_read;
						cmd_addr_q <= phy_addr_q;
						cmd_data_q <= phy_data_q;
						if (phy_addr_q == ID_MEAS_ADDR || phy_addr_q == ID_MEAS_SET_ADDR)
							cmd_data_q[ID_KEEP0_BIT] <= 1'b0;
					end
				end
				ST_ISSUE:
				begin
					cmd_wr_q <= 1'b0;
					cmd_rd_q <= 1'b0;
					state_q  <= is_read_q ? ST_WAIT : ST_IDLE;
				end
				ST_WAIT:
				begin
					state_q <= ST_IDLE;
				end
				default:
				begin
					state_q  <= ST_IDLE;
					cmd_wr_q <= 1'b0;
					cmd_rd_q <= 1'b0;
				end
			endcase
		end
	end

	// Captured read answer
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			rdata_q <= 8'h00;
		else if (rdone_set)
			rdata_q <= LINK.rd_data;
	end

	// Software read data, one cycle after the strobe
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
			sw_rdata_q <= 8'h00;
		else if (SW_RD)
		begin
			unique case (SW_ADDR)
				SW_PHY_ADDR_OFS: sw_rdata_q <= {2'h0, phy_addr_q};
				SW_PHY_DATA_OFS: sw_rdata_q <= phy_data_q;
				SW_CTRL_OFS:     sw_rdata_q <= {7'h00, state_q != ST_IDLE};
				SW_RDATA_OFS:    sw_rdata_q <= rdata_q;
				SW_IRQ_STAT_OFS: sw_rdata_q <= {6'h00, irq_stat_q};
				SW_IRQ_MASK_OFS: sw_rdata_q <= {6'h00, irq_mask_q};
				default:         sw_rdata_q <= 8'h00;
			endcase
		end
		else
			sw_rdata_q <= 8'h00;
	end

	assign SW_RDATA      = sw_rdata_q;
	assign IRQ           = |(irq_stat_q & irq_mask_q);
	assign LINK.cmd_wr   = cmd_wr_q;
	assign LINK.cmd_rd   = cmd_rd_q;
	assign LINK.cmd_addr = cmd_addr_q;
	assign LINK.cmd_data = cmd_data_q;

endmodule

// ===== sim/pvrb_asserts.sv
// Concurrent checks on the command channel between link end and transceiver end.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module pvrb_asserts
	import pvrb_pkg::*;
(
	// Clock and reset
	input  wire logic       CORE_CLK,
	input  wire logic       NRST,
	// Channel signals
	input  wire logic       cmd_wr,
	input  wire logic       cmd_rd,
	input  wire logic [5:0] cmd_addr,
	input  wire logic [7:0] cmd_data,
	input  wire logic       rd_valid,
	input  wire logic [7:0] rd_data,
	input  wire logic       rxcmd_valid,
	input  wire logic [7:0] rxcmd_data
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);

	// Address holds an implemented register
	wire logic mapped = (cmd_addr == TX_BOOST_ADDR) || (cmd_addr == AUDIO_KEY_ADDR)
		|| (cmd_addr >= ID_MEAS_ADDR && cmd_addr <= LINE_IO_ADDR + GROUP_CLR_STEP);

	// Reads of the two three-address groups
	sequence s_rd_id;
		cmd_rd && cmd_addr >= ID_MEAS_ADDR && cmd_addr <= ID_MEAS_CLR_ADDR;
	endsequence
	sequence s_rd_line;
		cmd_rd && cmd_addr >= LINE_IO_ADDR && cmd_addr <= LINE_IO_ADDR + GROUP_CLR_STEP;
	endsequence

	// Read answer stands for exactly one cycle
	sequence s_answer_pulse;
		rd_valid ##1 !rd_valid;
	endsequence

	chk_read_answer: assert property (cmd_rd |=> s_answer_pulse)
		else $error("read strobe not answered in the next cycle");
	chk_valid_cause: assert property (rd_valid |-> $past(cmd_rd))
		else $error("read answer without a read strobe");
	chk_one_strobe: assert property (!(cmd_wr && cmd_rd))
		else $error("write and read strobe together");
	chk_unmapped_zero: assert property (cmd_rd && !mapped |=> rd_data == 8'h00)
		else $error("unmapped address read not zero");
	chk_id_reserved: assert property (s_rd_id |=> rd_data[7] == 1'b0 && rd_data[5] == 1'b0)
		else $error("id register reserved bits not zero");
	chk_keep_zero: assert property (cmd_wr && (cmd_addr == ID_MEAS_ADDR
		|| cmd_addr == ID_MEAS_SET_ADDR) |-> !cmd_data[ID_KEEP0_BIT])
		else $error("keep-zero bit written as one");
	chk_line_bit0: assert property (s_rd_line |=> rd_data[0] == 1'b0)
		else $error("line register bit 0 not zero");
	chk_boost_rsvd: assert property (cmd_rd && cmd_addr == TX_BOOST_ADDR
		|=> rd_data[4:0] == 5'h00 && !rd_data[7])
		else $error("boost reserved bits not zero");
	chk_audio_rsvd: assert property (cmd_rd && cmd_addr == AUDIO_KEY_ADDR
		|=> rd_data[7:4] == 4'h0)
		else $error("audio key upper bits not zero");
	chk_rxcmd_byte: assert property (rxcmd_valid |-> rxcmd_data == RXCMD_ALT_BYTE
		&& !rd_valid ##1 !rxcmd_valid)
		else $error("status byte malformed");
endmodule

// ===== sim/tb_top.sv
// Self-checking bench: software port of the link end drives the transceiver end.
// Assumes a short conversion count so the run stays brief.
`timescale 1ns/1ps
module tb_top;
	import pvrb_pkg::*;
	logic       core_clk = 1'b0;
	logic       nrst     = 1'b0;
	logic [3:0] sw_addr  = 4'h0;
	logic [7:0] sw_wdata = 8'h00;
	logic       sw_wr    = 1'b0;
	logic       sw_rd    = 1'b0;
	logic [2:0] id_code  = 3'h0;
	logic       ck_en    = 1'b0;
	logic       uart     = 1'b0;
	logic       txd_en   = 1'b0;
	logic [7:0] sw_rdata;
	logic       irq;
	logic [1:0] boost;
	logic [1:0] ldo;
	logic [2:0] id_res;
	logic       audio, id_act, id_done, swap, pull_p, pull_m;
	logic [7:0] rv;
	logic [7:0] keys [4] = '{8'hfa, 8'h0b, 8'h05, 8'h0a};
	int         n_errors = 0;
	int         total_checks = 0;
	int         cycles = 0;
	localparam int CONV_SHORT = 8; // Shortened conversion length for the run

	pvrb_link_if pvrb_link_if_i ();
	pvrb_link_end pvrb_link_end_i (.CORE_CLK(core_clk), .NRST(nrst), .SW_ADDR(sw_addr),
		.SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd), .SW_RDATA(sw_rdata), .IRQ(irq),
		.LINK(pvrb_link_if_i));
	pvrb_phy_end #(.CONV_CYCLES(CONV_SHORT)) pvrb_phy_end_i (.CORE_CLK(core_clk), .NRST(nrst),
		.LINK(pvrb_link_if_i), .ID_RES_CODE_IN(id_code), .CARKIT_IRQ_EN(ck_en),
		.UART_MODE(uart), .SERIAL_TRANSMIT_DRIVE_ENABLE(txd_en), .TX_AMPLITUDE_BOOST(boost),
		.AUDIO_MODE_ENABLE(audio), .ID_MEASURE_ACTIVE(id_act), .ID_MEASURE_DONE(id_done),
		.ID_RESISTANCE_CODE(id_res), .LINE_POLARITY_SWAP(swap), .LDO_LEVEL(ldo),
		.CHARGER_PULLUP_PLUS(pull_p), .CHARGER_PULLUP_MINUS(pull_m));
	pvrb_asserts pvrb_asserts_i (.CORE_CLK(core_clk), .NRST(nrst),
		.cmd_wr(pvrb_link_if_i.cmd_wr), .cmd_rd(pvrb_link_if_i.cmd_rd),
		.cmd_addr(pvrb_link_if_i.cmd_addr), .cmd_data(pvrb_link_if_i.cmd_data),
		.rd_valid(pvrb_link_if_i.rd_valid), .rd_data(pvrb_link_if_i.rd_data),
		.rxcmd_valid(pvrb_link_if_i.rxcmd_valid), .rxcmd_data(pvrb_link_if_i.rxcmd_data));

	// Clock and hang limit
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			results();
		end
	end

	task automatic results();
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Software port cycles
	task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		#1;
		d = sw_rdata;
	endtask
	task automatic wait_idle();
		logic [7:0] c;
		c = 8'h01;
		repeat (20) if (c[0] !== 1'b0) sw_read(SW_CTRL_OFS, c);
		check(c & 8'h01, 8'h00);
	endtask

	// Transceiver register access through the link end
	task automatic phy_write(input logic [5:0] a, input logic [7:0] d);
		sw_write(SW_PHY_ADDR_OFS, {2'b00, a});
		sw_write(SW_PHY_DATA_OFS, d);
		sw_write(SW_CTRL_OFS, 8'h01);
		wait_idle();
	endtask
	task automatic phy_read(input logic [5:0] a, output logic [7:0] d);
		sw_write(SW_PHY_ADDR_OFS, {2'b00, a});
		sw_write(SW_CTRL_OFS, 8'h02);
		wait_idle();
		sw_read(SW_RDATA_OFS, d);
	endtask

	// One conversion with the given local enable, carkit enable and result code
	task automatic run_conv(input logic [7:0] en, input logic ck, input logic [2:0] code);
		logic [7:0] d;
		@(posedge core_clk);
		ck_en <= ck;
		id_code <= code;
		phy_write(ID_MEAS_ADDR, en);
		sw_write(SW_IRQ_STAT_OFS, 8'h03);
		phy_write(ID_MEAS_SET_ADDR, 8'h30);
		check({6'h0, id_done, id_act}, 8'h01);
		// Start was taken two edges before this point; done lands after the full count
		repeat (CONV_SHORT - 2) @(posedge core_clk);
		#1;
		check({7'h0, id_done}, 8'h00);
		@(posedge core_clk);
		#1;
		check({7'h0, id_done}, 8'h01);
		repeat (4) @(posedge core_clk);
		check({7'h0, id_act}, 8'h00);
		sw_read(SW_IRQ_STAT_OFS, d);
		check(d & 8'h02, {6'h0, en[6] | ck, 1'b0});
		phy_read(ID_MEAS_SET_ADDR, d);
		check(d, en | 8'h08 | {5'h0, code});
		phy_read(ID_MEAS_CLR_ADDR, d);
		check(d, en | {5'h0, code});
	endtask

	initial
	begin
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		// Values after reset
		phy_read(TX_BOOST_ADDR, rv);
		check(rv, 8'h00);
		phy_read(ID_MEAS_ADDR + GROUP_SET_STEP, rv);
		check(rv, 8'h00);
		phy_read(LINE_IO_ADDR, rv);
		check(rv, 8'h04);
		check({6'h0, ldo}, 8'h00);
		// Every boost code, reserved bits written as ones
		for (int k = 0; k < 4; k++)
		begin
			phy_write(TX_BOOST_ADDR, 8'h9f | (8'(k) << 5));
			phy_read(TX_BOOST_ADDR, rv);
			check(rv, 8'(k) << 5);
			check({6'h0, boost}, (k == 1) ? 8'h00 : 8'(k));
		end
		// Audio key: only the exact pattern enables
		phy_read(AUDIO_KEY_ADDR, rv);
		check(rv, 8'h00);
		foreach (keys[k])
		begin
			phy_write(AUDIO_KEY_ADDR, keys[k]);
			phy_read(AUDIO_KEY_ADDR, rv);
			check(rv, keys[k] & 8'h0f);
			check({7'h0, audio}, {7'h0, keys[k][3:0] == 4'ha});
		end
		// Line register: direct, set and clear
		phy_write(LINE_IO_ADDR, 8'hff);
		phy_read(LINE_IO_ADDR + GROUP_CLR_STEP, rv);
		check(rv, 8'hfe);
		phy_write(LINE_IO_ADDR, 8'h00);
		phy_write(LINE_IO_ADDR + GROUP_SET_STEP, 8'h52);
		phy_read(LINE_IO_ADDR + GROUP_SET_STEP, rv);
		check(rv, 8'h52);
		check({5'h0, swap, pull_m, pull_p}, 8'h05);
		check({6'h0, ldo}, 8'h01);
		phy_write(LINE_IO_ADDR + GROUP_CLR_STEP, 8'h12);
		phy_write(LINE_IO_ADDR + GROUP_SET_STEP, 8'h2c);
		phy_read(LINE_IO_ADDR, rv);
		check(rv, 8'h6c);
		check({5'h0, swap, pull_m, pull_p}, 8'h02);
		// Serial mode: pull-ups forced, serial level only with transmit drive
		@(posedge core_clk);
		uart <= 1'b1;
		phy_write(LINE_IO_ADDR + GROUP_CLR_STEP, 8'h20);
		check({6'h0, pull_m, pull_p}, 8'h03);
		check({6'h0, ldo}, 8'h01);
		@(posedge core_clk);
		txd_en <= 1'b1;
		repeat (3) @(posedge core_clk);
		check({6'h0, ldo}, 8'h03);
		// Unmapped places read zero and ignore writes
		phy_write(VND_HIGH_ADDR, 8'hff);
		phy_read(VND_HIGH_ADDR, rv);
		check(rv, 8'h00);
		phy_read(VND_LOW_ADDR, rv);
		check(rv, 8'h00);
		sw_read(4'hf, rv);
		check(rv, 8'h00);
		// Conversions: local enable, carkit enable, neither
		sw_write(SW_IRQ_MASK_OFS, 8'h02);
		run_conv(8'h40, 1'b0, 3'h5);
		check({7'h0, irq}, 8'h01);
		sw_write(SW_IRQ_STAT_OFS, 8'h02);
		#1;
		check({7'h0, irq}, 8'h00);
		run_conv(8'h00, 1'b1, 3'h7);
		sw_write(SW_IRQ_MASK_OFS, 8'h00);
		#1;
		check({7'h0, irq}, 8'h00);
		run_conv(8'h00, 1'b0, 3'h2);
		check({5'h0, id_res}, 8'h02);
		results();
	end
endmodule
